/* File: pkg/fcsm_pkg.sv */
// constants for the parallel flash command sequencer (host end)
package fcsm_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int REG_AW = 3;
  localparam int REG_DW = 32;
  // register offsets
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_CFG = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_RDATA = 3'h5;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TLE = 2;
  localparam int ST_RDY = 3;
  localparam logic CFG_BYTE_RST = 1'b0;
  // operations
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_AUTOSEL = 3'h2;
  localparam logic [2:0] OP_PROG = 3'h3;
  localparam logic [2:0] OP_BYP_ENTER = 3'h4;
  localparam logic [2:0] OP_BYP_PROG = 3'h5;
  localparam logic [2:0] OP_BYP_EXIT = 3'h6;
  localparam logic [2:0] OP_ERASE = 3'h7;
  localparam int PROG_WRITES = 4;
  localparam int ERASE_WRITES = 6;
  // sequence table entry layout
  localparam int ENT_W = 23;
  localparam int ENT_RD = 22;
  localparam int ENT_USER = 21;
  localparam int ENT_LAST = 20;
  localparam int ENT_AHI = 19;
  localparam int ENT_ALO = 8;
  localparam int SEQ_AW = 6;
  // bus codes
  localparam logic [11:0] UNLOCK_A1 = 12'h555;
  localparam logic [11:0] UNLOCK_A2 = 12'h2aa;
  localparam logic [11:0] ANY_A = 12'h000;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam int TLE_BIT = 5;
  // timing
  localparam int CLK_NS = 100;
  localparam int T_WP_NS = 60;
  localparam int T_ACC_NS = 90;
  localparam int T_BUSY_NS = 90;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
endpackage

/* File: design/fcsm_seq_rom.sv */
// command sequence table with registered read data
`timescale 1ns/1ps
module fcsm_seq_rom
  import fcsm_pkg::*;
#(
  parameter int AW = SEQ_AW,
  parameter int DW = ENT_W
)
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic ce_en, // clock enable
  input wire logic [AW-1:0] raddr, // {op, step}
  output logic [DW-1:0] rdata_q // entry, one cycle later
);
  import fcsm_pkg::*;

  function automatic logic [DW-1:0] mk(input logic rd, input logic usr,
    input logic last, input logic [11:0] a, input logic [7:0] d);
    mk = {rd, usr, last, a, d};
  endfunction

  logic [DW-1:0] ent;

  always_comb
  begin
    ent = mk(1'b0, 1'b0, 1'b1, ANY_A, CMD_RESET);
    unique case (raddr)
      {OP_READ, 3'h0}: ent = mk(1'b1, 1'b1, 1'b1, ANY_A, 8'h00);
      {OP_RESET, 3'h0}: ent = mk(1'b0, 1'b0, 1'b1, ANY_A, CMD_RESET);
      {OP_AUTOSEL, 3'h0}, {OP_PROG, 3'h0}, {OP_BYP_ENTER, 3'h0},
      {OP_ERASE, 3'h0}, {OP_ERASE, 3'h3}:
        ent = mk(1'b0, 1'b0, 1'b0, UNLOCK_A1, CMD_UNLOCK1);
      {OP_AUTOSEL, 3'h1}, {OP_PROG, 3'h1}, {OP_BYP_ENTER, 3'h1},
      {OP_ERASE, 3'h1}, {OP_ERASE, 3'h4}:
        ent = mk(1'b0, 1'b0, 1'b0, UNLOCK_A2, CMD_UNLOCK2);
      {OP_AUTOSEL, 3'h2}: ent = mk(1'b0, 1'b0, 1'b0, UNLOCK_A1, CMD_AUTOSEL);
      {OP_AUTOSEL, 3'h3}: ent = mk(1'b1, 1'b1, 1'b0, ANY_A, 8'h00);
      {OP_AUTOSEL, 3'h4}: ent = mk(1'b0, 1'b0, 1'b1, ANY_A, CMD_RESET);
      {OP_PROG, 3'h2}: ent = mk(1'b0, 1'b0, 1'b0, UNLOCK_A1, CMD_PROG);
      {OP_PROG, 3'h3}: ent = mk(1'b0, 1'b1, 1'b1, ANY_A, 8'h00);
      {OP_BYP_ENTER, 3'h2}:
        ent = mk(1'b0, 1'b0, 1'b1, UNLOCK_A1, CMD_BYPASS);
      {OP_BYP_PROG, 3'h0}: ent = mk(1'b0, 1'b0, 1'b0, ANY_A, CMD_PROG);
      {OP_BYP_PROG, 3'h1}: ent = mk(1'b0, 1'b1, 1'b1, ANY_A, 8'h00);
      {OP_BYP_EXIT, 3'h0}: ent = mk(1'b0, 1'b0, 1'b0, ANY_A, CMD_BYP_EXIT1);
      {OP_BYP_EXIT, 3'h1}: ent = mk(1'b0, 1'b0, 1'b1, ANY_A, CMD_BYP_EXIT2);
      {OP_ERASE, 3'h2}:
        ent = mk(1'b0, 1'b0, 1'b0, UNLOCK_A1, CMD_ERASE_SETUP);
      {OP_ERASE, 3'h5}:
        ent = mk(1'b0, 1'b0, 1'b1, UNLOCK_A1, CMD_CHIP_ERASE);
      default: ent = mk(1'b0, 1'b0, 1'b1, ANY_A, CMD_RESET);
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    else if (ce_en)
      rdata_q <= ent;
  end
endmodule

/* File: design/fcsm_ctrl.sv */
// host controller driving the flash command interface
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module fcsm_ctrl
  import fcsm_pkg::*;
(
  input wire logic clk, // system clock, 10 MHz
  input wire logic rst, // async reset, active high
  input wire logic ce_en, // clock enable, freezes state when low
  input wire logic [fcsm_pkg::REG_AW-1:0] reg_addr, // register index
  input wire logic [fcsm_pkg::REG_DW-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [fcsm_pkg::REG_DW-1:0] reg_rdata, // read data, next cycle
  output logic [fcsm_pkg::ADDR_W-1:0] flash_addr, // flash address pins
  output logic [fcsm_pkg::DATA_W-1:0] flash_dq_out, // data pins, driven
  output logic flash_dq_oe, // data pins driven when high
  input wire logic [fcsm_pkg::DATA_W-1:0] flash_dq_in, // data pins, sampled
  output logic flash_ce_n, // chip select, low active
  output logic flash_we_n, // write strobe, low active
  output logic flash_oe_n, // output enable, low active
  output logic flash_byte_n, // bus width select, low for bytes
  input wire logic ready_busy_n // low while embedded operation runs
);
  import fcsm_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_FETCH, S_LOAD, S_WR_SETUP, S_WR_PULSE, S_WR_END,
    S_RD_WAIT, S_BUSYWAIT
  } fcsm_state_type;

  fcsm_state_type state_q;
  logic [2:0] op_q;
  logic [2:0] step_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic byte_mode_q;
  logic done_q;
  logic tle_q;
  logic poll_q;
  logic last_q;
  logic user_q;
  logic [DATA_W-1:0] rdata_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] wr_cnt_q;
  logic [ENT_W-1:0] ent;
  logic start;
  logic polls;
  logic tle_hit;
  logic [11:0] ent_a;
  logic [ADDR_W-1:0] tbl_addr;

  fcsm_seq_rom u_rom (
    .clk(clk),
    .rst(rst),
    .ce_en(ce_en),
    .raddr({op_q, step_q}),
    .rdata_q(ent)
  );

  assign start = reg_wr && reg_addr == REG_CMD && state_q == S_IDLE;
  assign polls = op_q == OP_PROG || op_q == OP_BYP_PROG || op_q == OP_ERASE;
  assign ent_a = ent[ENT_AHI:ENT_ALO];
  // byte mode doubles the command offsets
  assign tbl_addr = byte_mode_q ? {7'h00, ent_a, 1'b0} : {8'h00, ent_a};
  assign tle_hit = state_q == S_RD_WAIT && cnt_q == CNT_W'(1) && poll_q &&
    !ready_busy_n && flash_dq_in[TLE_BIT];

  // software registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= '0;
      wdata_q <= '0;
      byte_mode_q <= CFG_BYTE_RST;
    end
    else if (ce_en && reg_wr)
    begin
      unique case (reg_addr)
        REG_ADDR: addr_q <= reg_wdata[ADDR_W-1:0];
        REG_WDATA: wdata_q <= reg_wdata[DATA_W-1:0];
        REG_CFG: byte_mode_q <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (ce_en)
    begin
      reg_rdata <= '0;
      if (reg_rd)
      begin
        unique case (reg_addr)
          REG_CMD: reg_rdata <= {29'h0, op_q};
          REG_ADDR: reg_rdata <= {12'h000, addr_q};
          REG_WDATA: reg_rdata <= {16'h0000, wdata_q};
          REG_CFG: reg_rdata <= {31'h0, byte_mode_q};
          REG_STATUS: reg_rdata <= {28'h0, ready_busy_n, tle_q, done_q,
            state_q != S_IDLE};
          REG_RDATA: reg_rdata <= {16'h0000, rdata_q};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flash_byte_n <= 1'b1;
    else if (ce_en)
      flash_byte_n <= !byte_mode_q;
  end

  // write pulse counter per operation
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wr_cnt_q <= '0;
    else if (ce_en)
    begin
      if (start)
        wr_cnt_q <= '0;
      else if (state_q == S_WR_SETUP)
        wr_cnt_q <= wr_cnt_q + 4'h1;
    end
  end

  // sequencer and pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      op_q <= OP_READ;
      step_q <= '0;
      done_q <= 1'b0;
      tle_q <= 1'b0;
      poll_q <= 1'b0;
      last_q <= 1'b0;
      user_q <= 1'b0;
      cnt_q <= '0;
      rdata_q <= '0;
      flash_addr <= '0;
      flash_dq_out <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end
    else if (ce_en)
    begin
      unique case (state_q)
        S_IDLE:
          if (start)
          begin
            op_q <= reg_wdata[2:0];
            step_q <= '0;
            done_q <= 1'b0;
            tle_q <= 1'b0;
            poll_q <= 1'b0;
            state_q <= S_FETCH;
          end
        S_FETCH:
          state_q <= S_LOAD;
        S_LOAD:
        begin
          last_q <= ent[ENT_LAST];
          user_q <= ent[ENT_USER];
          flash_addr <= ent[ENT_USER] ? addr_q : tbl_addr;
          flash_ce_n <= 1'b0;
          if (ent[ENT_RD])
          begin
            flash_oe_n <= 1'b0;
            cnt_q <= CNT_W'(ACC_CYC);
            state_q <= S_RD_WAIT;
          end
          else
          begin
            flash_dq_out <= ent[ENT_USER] ? wdata_q : {8'h00, ent[7:0]};
            flash_dq_oe <= 1'b1;
            state_q <= S_WR_SETUP;
          end
        end
        S_WR_SETUP:
        begin
          flash_we_n <= 1'b0;
          cnt_q <= CNT_W'(WP_CYC);
          state_q <= S_WR_PULSE;
        end
        S_WR_PULSE:
          if (cnt_q == CNT_W'(1))
          begin
            flash_we_n <= 1'b1;
            state_q <= S_WR_END;
          end
          else
            cnt_q <= cnt_q - CNT_W'(1);
        S_WR_END:
        begin
          flash_ce_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          if (!last_q)
          begin
            step_q <= step_q + 3'h1;
            state_q <= S_FETCH;
          end
          else if (polls && op_q != OP_RESET)
          begin
            cnt_q <= CNT_W'(BUSY_CYC);
            state_q <= S_BUSYWAIT;
          end
          else
          begin
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_RD_WAIT:
          if (cnt_q == CNT_W'(1))
          begin
            rdata_q <= flash_dq_in;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            if (poll_q && ready_busy_n)
            begin
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
            else if (tle_hit)
            begin
              tle_q <= 1'b1;
              op_q <= OP_RESET;
              step_q <= '0;
              poll_q <= 1'b0;
              state_q <= S_FETCH;
            end
            else if (poll_q)
            begin
              cnt_q <= CNT_W'(BUSY_CYC);
              state_q <= S_BUSYWAIT;
            end
            else if (!last_q)
            begin
              step_q <= step_q + 3'h1;
              state_q <= S_FETCH;
            end
            else
            begin
              done_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
          else
            cnt_q <= cnt_q - CNT_W'(1);
        S_BUSYWAIT:
          if (cnt_q == CNT_W'(1))
          begin
            // status read at the target address
            flash_addr <= addr_q;
            flash_ce_n <= 1'b0;
            flash_oe_n <= 1'b0;
            poll_q <= 1'b1;
            cnt_q <= CNT_W'(ACC_CYC);
            state_q <= S_RD_WAIT;
          end
          else
            cnt_q <= cnt_q - CNT_W'(1);
      endcase
    end
  end

  a_tle_reset_write: assert property (
    @(posedge clk) disable iff (rst || !ce_en)
    tle_hit |-> ##[1:12] (!flash_we_n && flash_dq_out[7:0] == CMD_RESET))
    else $error("no reset write after time limit status");

  a_autosel_exit: assert property (
    @(posedge clk) disable iff (rst || !ce_en)
    (state_q == S_RD_WAIT && cnt_q == 4'h1 && op_q == OP_AUTOSEL)
    |-> ##[1:12] (!flash_we_n && flash_dq_out[7:0] == CMD_RESET))
    else $error("autoselect left without reset write");

  a_prog_cycles: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == S_BUSYWAIT && $past(state_q) == S_WR_END &&
     op_q == OP_PROG) |-> wr_cnt_q == 4'(PROG_WRITES))
    else $error("program launched after wrong write count");

  a_erase_cycles: assert property (
    @(posedge clk) disable iff (rst)
    (state_q == S_BUSYWAIT && $past(state_q) == S_WR_END &&
     op_q == OP_ERASE) |-> wr_cnt_q == 4'(ERASE_WRITES))
    else $error("chip erase launched after wrong write count");

  a_bypass_exit_data: assert property (
    @(posedge clk) disable iff (rst)
    ($fell(flash_we_n) && op_q == OP_BYP_EXIT) |->
    flash_dq_out[7:0] == (wr_cnt_q == 4'h1 ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2))
    else $error("bypass exit data wrong");

  a_unlock_addr: assert property (
    @(posedge clk) disable iff (rst || !ce_en)
    ($fell(flash_we_n) && !user_q && flash_dq_out[7:0] == CMD_UNLOCK1) |->
    (byte_mode_q ? flash_addr[12:1] : flash_addr[11:0]) == UNLOCK_A1 ##1
    flash_we_n ##1 (flash_we_n && !flash_dq_oe))
    else $error("first unlock not at its offset");
endmodule

/* File: test/fcsm_flash_model.sv */
// behavioural parallel flash device seen by the controller
`timescale 1ns/1ps
module fcsm_flash_model
  import fcsm_pkg::*;
#(
  parameter logic [15:0] MAKER = 16'h00c5, // arbitrary value
  parameter logic [15:0] DEVID = 16'h5a3c, // arbitrary value
  parameter logic [15:0] CONTID = 16'h0042, // arbitrary value
  parameter int OP_NS = 2030
)
(
  input wire logic [fcsm_pkg::ADDR_W-1:0] addr, // address pins
  input wire logic [fcsm_pkg::DATA_W-1:0] dq_w, // data pin level
  input wire logic ce_n, // chip select
  input wire logic we_n, // write strobe
  input wire logic oe_n, // output enable
  input wire logic byte_n, // width select
  output logic [fcsm_pkg::DATA_W-1:0] dq_r, // data to host
  output logic ready_busy_n // low while busy
);
  import fcsm_pkg::*;
  logic [15:0] mem [256];
  logic [15:0] last = '0;
  logic [15:0] rv;
  logic [ADDR_W-1:0] la = '0;
  logic busy = 1'b0;
  logic tle = 1'b0;
  logic tgl = 1'b0;
  int mode = 0;
  int seq = 0;
  int gen = 0;
  wire wr_act = !ce_n && !we_n && oe_n;
  wire drv = !ce_n && !oe_n;
  wire [11:0] ca = byte_n ? la[11:0] : la[12:1];
  wire [7:0] ro = byte_n ? addr[7:0] : addr[8:1];
  initial
    foreach (mem[i]) mem[i] = 16'hffff;
  task automatic launch();
    int g;
    gen++;
    g = gen;
    busy = 1'b1;
    fork
      begin
        #(OP_NS);
        if (!tle && g == gen) busy = 1'b0;
      end
    join_none
  endtask
  task automatic prog(input logic [15:0] w);
    if (!byte_n) w[15:8] = 8'hff;
    seq = 0;
    tle = |(w & ~mem[la[7:0]]);
    mem[la[7:0]] = mem[la[7:0]] & w;
    launch();
  endtask
  task automatic cmd(input logic [15:0] w);
    logic [7:0] d;
    logic u1, u2, at;
    d = w[7:0];
    u1 = ca == UNLOCK_A1 && d == CMD_UNLOCK1;
    u2 = ca == UNLOCK_A2 && d == CMD_UNLOCK2;
    at = ca == UNLOCK_A1;
    if (busy)
    begin
      if (tle && d == CMD_RESET) busy = 1'b0;
      if (d == CMD_RESET) tle = 1'b0;
    end
    else if (d == CMD_RESET && mode != 2)
    begin
      mode = 0;
      seq = 0;
    end
    else if (mode == 1)
      seq = 0;
    else
      case (seq)
        0: if (mode == 2)
          seq = d == CMD_PROG ? 7 : d == CMD_BYP_EXIT1 ? 8 : 0;
        else
          seq = u1 ? 1 : 0;
        1: seq = u2 ? 2 : 0;
        2:
        begin
          seq = !at ? 0 : d == CMD_PROG ? 3 : d == CMD_ERASE_SETUP ? 4 : 0;
          if (at && d == CMD_AUTOSEL) mode = 1;
          if (at && d == CMD_BYPASS) mode = 2;
        end
        3, 7: prog(w);
        4: seq = u1 ? 5 : 0;
        5: seq = u2 ? 6 : 0;
        6:
        begin
          seq = 0;
          if (at && d == CMD_CHIP_ERASE)
          begin
            foreach (mem[i]) mem[i] = 16'hffff;
            tle = 1'b0;
            launch();
          end
        end
        8:
        begin
          seq = 0;
          if (d == CMD_BYP_EXIT2) mode = 0;
        end
        default: seq = 0;
      endcase
  endtask
  always @(posedge wr_act) la = addr;
  always @(negedge wr_act) cmd(dq_w);
  always @(negedge oe_n) tgl = !tgl;
  always @*
    if (busy)
      rv = {8'h00, ~mem[la[7:0]][7], tgl, tle, 2'b00, tgl, 2'b00};
    else if (mode == 1)
      case (ro)
        8'h00: rv = MAKER;
        8'h01: rv = DEVID;
        8'h02: rv = {15'h0000, addr[19]};
        8'h03: rv = CONTID;
        default: rv = 16'h0000;
      endcase
    else
      rv = mem[ro];
  // released pins show a changed value
  always @*
    if (drv) last = byte_n ? rv : {8'h00, rv[7:0]};
  assign dq_r = drv ? last : ~last;
  assign ready_busy_n = !busy;
endmodule

/* File: test/testbench.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
  import fcsm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [19:0] flash_addr;
  logic [15:0] flash_dq_out, dev_q;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic flash_byte_n, ready_busy_n;
  logic saw_busy = 1'b0;
  logic ce_en = 1'b1;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire [15:0] bus = flash_dq_oe ? flash_dq_out : dev_q;
  always #50 clk = !clk;
  fcsm_ctrl dut (.clk(clk), .rst(rst), .ce_en(ce_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(bus), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_byte_n(flash_byte_n),
    .ready_busy_n(ready_busy_n));
  fcsm_flash_model dev (.addr(flash_addr), .dq_w(bus), .ce_n(flash_ce_n),
    .we_n(flash_we_n), .oe_n(flash_oe_n), .byte_n(flash_byte_n),
    .dq_r(dev_q), .ready_busy_n(ready_busy_n));
  always @(posedge clk)
    if (ready_busy_n === 1'b0) saw_busy <= 1'b1;
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 300 && s[ST_BUSY] !== 1'b0; i++)
      rd(REG_STATUS, s);
    chk(32'(s[ST_BUSY]), 32'h0);
  endtask
  task automatic run(input logic [2:0] op, input logic [19:0] ad);
    wr(REG_ADDR, 32'(ad));
    wr(REG_CMD, {29'h0, op});
    wait_idle();
  endtask
  task automatic rd_at(input logic [19:0] ad, input logic [31:0] exp);
    logic [31:0] v;
    run(OP_READ, ad);
    rd(REG_RDATA, v);
    chk(v, exp);
  endtask
  task automatic t_reset();
    logic [31:0] v;
    chk(32'({flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe}), 32'he);
    rd(3'h7, v);
    chk(v, 32'h0);
    rd_at(20'h00010, 32'hffff);
    $display("test reset done");
  endtask
  task automatic t_freeze();
    logic [31:0] p, v;
    wr(REG_ADDR, 32'h10);
    wr(REG_CMD, {29'h0, OP_READ});
    repeat (2) @(posedge clk);
    ce_en <= 1'b0;
    @(posedge clk);
    #1;
    p = 32'({flash_addr, flash_ce_n, flash_oe_n, flash_we_n});
    chk(32'(p[2:1]), 32'h0);
    repeat (5) @(posedge clk);
    #1;
    chk(32'({flash_addr, flash_ce_n, flash_oe_n, flash_we_n}), p);
    @(posedge clk);
    ce_en <= 1'b1;
    wait_idle();
    rd(REG_RDATA, v);
    chk(v, 32'hffff);
    $display("test clock enable done");
  endtask
  task automatic t_prog();
    logic [31:0] v;
    saw_busy = 1'b0;
    wr(REG_WDATA, 32'h1234);
    run(OP_PROG, 20'h00010);
    rd(REG_STATUS, v);
    chk(32'(v[2:1]), 32'h1);
    chk(32'(saw_busy), 32'h1);
    rd_at(20'h00010, 32'h1234);
    $display("test program done");
  endtask
  task automatic t_tle();
    logic [31:0] v;
    wr(REG_WDATA, 32'h12ff);
    run(OP_PROG, 20'h00010);
    rd(REG_STATUS, v);
    chk(32'(v[ST_TLE]), 32'h1);
    chk(32'(ready_busy_n), 32'h1);
    rd_at(20'h00010, 32'h1234);
    $display("test time limit done");
  endtask
  task automatic t_auto();
    logic [31:0] v;
    logic [19:0] ad [5] = '{20'h00000, 20'h00001, 20'h00003,
      20'h80002, 20'h00002};
    logic [15:0] ex [5] = '{dev.MAKER, dev.DEVID, dev.CONTID,
      16'h0001, 16'h0000};
    for (int i = 0; i < 5; i++)
    begin
      run(OP_AUTOSEL, ad[i]);
      rd(REG_RDATA, v);
      chk(v, 32'(ex[i]));
    end
    rd_at(20'h00010, 32'h1234);
    $display("test autoselect done");
  endtask
  task automatic t_byp();
    run(OP_BYP_ENTER, 20'h0);
    wr(REG_WDATA, 32'h00aa);
    run(OP_BYP_PROG, 20'h00020);
    run(OP_RESET, 20'h0);
    wr(REG_WDATA, 32'h5555);
    run(OP_BYP_PROG, 20'h00021);
    run(OP_BYP_EXIT, 20'h0);
    rd_at(20'h00020, 32'h00aa);
    rd_at(20'h00021, 32'h5555);
    $display("test bypass done");
  endtask
  task automatic t_erase();
    saw_busy = 1'b0;
    run(OP_ERASE, 20'h0);
    chk(32'(saw_busy), 32'h1);
    rd_at(20'h00010, 32'hffff);
    $display("test erase done");
  endtask
  task automatic t_byte();
    logic [31:0] v;
    wr(REG_CFG, 32'h1);
    @(posedge clk);
    #1;
    chk(32'(flash_byte_n), 32'h0);
    run(OP_AUTOSEL, 20'h0);
    rd(REG_RDATA, v);
    chk(v, 32'(dev.MAKER[7:0]));
    wr(REG_CFG, 32'h0);
    $display("test byte mode done");
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_freeze();
    t_prog();
    t_tle();
    t_auto();
    t_byp();
    t_erase();
    t_byte();
    final_report();
  end
endmodule
